//--- bench/sled_bus_model.sv
`timescale 1ns/100ps
// far end of the expansion bus: the first module answers while the adapter holds the token
module sled_bus_model (
	// clock
	input wire logic clk,
	// adapter pins
	input wire logic token,
	input wire logic ser_from_adapter,
	output logic ser_to_adapter
);
	initial ser_to_adapter = 1'b1;
	// echo while holding the token; the released line has no pull-up, so it toggles instead of holding
	always @(posedge clk) begin
		if (token) begin
			ser_to_adapter <= ser_from_adapter;
		end else begin
			ser_to_adapter <= ~ser_to_adapter;
		end
	end
endmodule // sled_bus_model

//--- bench/sled_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
	import sled_pkg::*;
	// clock and reset
	logic mclk = 1'b0;
	logic srst = 1'b1;
	// controller inputs
	logic fw = 1'b0, csum = 1'b0, ecfg = 1'b0, eloc = 1'b0, epd = 1'b0, eboot = 1'b0, epdi = 1'b0;
	logic [31:0] ser = 32'h00000000;
	logic [3:0] slv = 4'h1;
	logic pres = 1'b0, pwr = 1'b0, passed = 1'b0, ufault = 1'b0, xid = 1'b0, xproto = 1'b0, xvend = 1'b0;
	logic [6:0] slots = 7'h00;
	logic [8:0] in_b = 9'h000, out_b = 9'h000;
	logic tok_req = 1'b0, tx_data = 1'b1, xb_fs = 1'b0, fpwr = 1'b0;
	sled_msg_t fc = SLED_MSG_SERVICE;
	// design outputs
	logic xb_rx, xb_svc, xb_io, xb_ovf, xb_tok, xb_sout, xb_sin;
	logic [6:0] led;
	// bench model state
	int errors = 0, check_count = 0, xst = 0;
	int exp_c [7];
	bit io_seen = 0;
	logic [3:0] codes [6] = '{SLED_ST_INIT, SLED_ST_PREOP, SLED_ST_BOOT, SLED_ST_SAFEOP, SLED_ST_OP, 4'hf};

	sled_top #(.STEP_CYCLES(4)) dut_u (
		.MCLK(mclk), .SRST(srst), .FW_FAULT(fw), .STORE_CSUM_FAULT(csum), .SERIAL_NUM(ser), .SLV_STATE(slv),
		.ERR_CFG_INVALID(ecfg), .ERR_LOCAL_CHANGE(eloc), .ERR_PD_WDOG(epd), .ERR_BOOT(eboot), .ERR_PDI_WDOG(epdi),
		.XB_UNIT_PRESENT(pres), .XB_POWERED(pwr), .XB_CFG_PASSED(passed), .XB_UNIT_FAULT(ufault),
		.XB_ID_INVALID(xid), .XB_PROTO_FAIL(xproto), .XB_VENDOR_MISMATCH(xvend), .XB_SLOT_COUNT(slots),
		.XB_IN_BYTES(in_b), .XB_OUT_BYTES(out_b), .XB_TOKEN_REQ(tok_req), .XB_TX_DATA(tx_data),
		.XB_FRAME_START(xb_fs), .XB_FRAME_CLASS(fc), .XB_RX_DATA(xb_rx), .XB_SVC_MSG(xb_svc), .XB_IO_MSG(xb_io),
		.XB_CFG_OVERFLOW(xb_ovf), .XB_TOKEN_OUT(xb_tok), .XB_SER_OUT(xb_sout), .XB_SER_IN(xb_sin),
		.FIELD_PWR_IN(fpwr), .HEALTH_LED_GRN(led[0]), .HEALTH_LED_RED(led[1]), .RUN_LED(led[2]),
		.ERR_LED(led[3]), .XIO_LED_GRN(led[4]), .XIO_LED_RED(led[5]), .FPWR_LED(led[6])
	);
	sled_bus_model bus_u (.clk(mclk), .token(xb_tok), .ser_from_adapter(xb_sout), .ser_to_adapter(xb_sin));

	// clock
	always #5 mclk = ~mclk;

	task automatic end_of_test;
		if (errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// pattern code from one frame of samples: 0 off, 1 on, 2 blink, 3 single, 4 double, 5 flash
	function automatic int cls(int on, int rs);
		if (on == 0) return 0;
		if (on == 128) return 1;
		if (on == 64 && rs == 4) return 2;
		if (on == 16 && rs == 1) return 3;
		if (on == 32 && rs == 2) return 4;
		if (on == 64 && rs == 16) return 5;
		return 15;
	endfunction

	// expected LED patterns from the current inputs
	task automatic compute_exp;
		bit fail;
		fail = xid | xproto | xvend | (slots > 7'h3f) | (in_b > 9'h0fc) | (out_b > 9'h0fc);
		exp_c[0] = fw ? 0 : csum ? 0 : (ser == 32'h00000000) ? 5 : 1;
		exp_c[1] = fw ? 1 : csum ? 5 : 0;
		exp_c[2] = (slv == SLED_ST_PREOP) ? 2 : (slv == SLED_ST_SAFEOP) ? 3 : (slv == SLED_ST_BOOT) ? 5 :
			(slv == SLED_ST_OP) ? 1 : 0;
		exp_c[3] = epdi ? 1 : eboot ? 5 : epd ? 4 : eloc ? 3 : ecfg ? 2 : 0;
		// iterate so chained moves such as failure cleared, off, configured settle
		repeat (4) begin
			if (!pres || !pwr) xst = 0;
			else if (xst <= 1 && fail) xst = 4;
			else if (xst == 4) xst = fail ? 4 : 0;
			else if (xst == 1 && io_seen) xst = 2;
			else if (xst <= 1) xst = passed ? 1 : 0;
			else if (xst == 2 && ufault) xst = 3;
		end
		exp_c[4] = (xst == 1) ? 5 : (xst == 2) ? 1 : 0;
		exp_c[5] = (xst == 3) ? 1 : (xst == 4) ? 5 : 0;
		exp_c[6] = fpwr ? 1 : 0;
	endtask

	// settle, then watch one whole pattern frame while toggling the bus pins at random
	task automatic check_all;
		logic [6:0] prv;
		int on [7];
		int rs [7];
		logic ptok, ptx, r1, r2;
		int hq[$];
		int erx = -1;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		compute_exp();
		`CHK(xb_ovf, (slots > 7'h3f) || (in_b > 9'h0fc) || (out_b > 9'h0fc))
		prv = led;
		ptok = tok_req;
		ptx = tx_data;
		hq.push_back(int'(xb_sin));
		for (int k = 0; k < 7; k++) begin
			on[k] = 0;
			rs[k] = 0;
		end
		for (int i = 0; i < 128; i++) begin
			r1 = 1'($urandom);
			r2 = 1'($urandom);
			@(posedge mclk);
			tok_req <= r1;
			tx_data <= r2;
			@(negedge mclk);
			`CHK(xb_tok, ptok)
			`CHK(xb_sout, ptx)
			// receive pin: three stages, a new level is taken once two older samples agree
			if (hq.size() == 4 && hq[0] == hq[1]) erx = hq[0];
			if (erx >= 0) `CHK(xb_rx, erx[0])
			hq.push_back(int'(xb_sin));
			if (hq.size() > 4) hq.pop_front();
			ptok = r1;
			ptx = r2;
			for (int k = 0; k < 7; k++) begin
				if (led[k] === 1'b1) on[k]++;
				else if (led[k] !== 1'b0) on[k] = 999;
				if (led[k] === 1'b1 && prv[k] === 1'b0) rs[k]++;
			end
			prv = led;
		end
		`CHK(cls(on[0], rs[0]), exp_c[0])
		`CHK(cls(on[1], rs[1]), exp_c[1])
		`CHK(cls(on[2], rs[2]), exp_c[2])
		`CHK(cls(on[3], rs[3]), exp_c[3])
		`CHK(cls(on[4], rs[4]), exp_c[4])
		`CHK(cls(on[5], rs[5]), exp_c[5])
		`CHK(cls(on[6], rs[6]), exp_c[6])
	endtask

	// one frame pulse, class answered exactly one cycle later
	task automatic send_frame(input sled_msg_t c);
		@(posedge mclk);
		xb_fs <= 1'b1;
		fc <= c;
		@(posedge mclk);
		xb_fs <= 1'b0;
		@(negedge mclk);
		`CHK(xb_svc, c == SLED_MSG_SERVICE)
		`CHK(xb_io, c == SLED_MSG_IO)
		if (c == SLED_MSG_IO && passed) io_seen = 1;
		check_all();
	endtask

	task automatic xset(input logic p, w, g, f, a, b, v, input logic [6:0] s, input logic [8:0] ib, ob);
		@(posedge mclk);
		{pres, pwr, passed, ufault, xid, xproto, xvend} <= {p, w, g, f, a, b, v};
		slots <= s;
		in_b <= ib;
		out_b <= ob;
		if (!g) io_seen = 0;
		check_all();
	endtask

	// a hang counts as a mismatch; the run needs well under a fifth of this
	initial begin
		#400000;
		errors++;
		end_of_test();
	end

	initial begin
		void'($urandom(89));
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		`CHK(led, 7'h00)
		`CHK({xb_tok, xb_sout, xb_rx, xb_svc, xb_io, xb_ovf}, 6'h18)
		@(posedge mclk);
		srst <= 1'b0;
		// health, run, error and field power under random inputs, expansion bus absent
		repeat (24) begin
			@(posedge mclk);
			fw <= ($urandom % 4) == 0;
			csum <= ($urandom % 3) == 0;
			ser <= ($urandom % 3 == 0) ? 32'h00000000 : $urandom;
			slv <= codes[$urandom % 6];
			{epdi, eboot, epd, eloc, ecfg} <= 5'($urandom);
			fpwr <= 1'($urandom);
			check_all();
		end
		// expansion path: present but unpowered, configured at the limits, exchange, fault held, power removed
		xset(1, 0, 1, 0, 0, 0, 0, 7'h3f, 9'h0fc, 9'h0fc);
		xset(1, 1, 1, 0, 0, 0, 0, 7'h3f, 9'h0fc, 9'h0fc);
		send_frame(SLED_MSG_SERVICE);
		send_frame(SLED_MSG_IO);
		xset(1, 1, 1, 1, 0, 0, 0, 7'h3f, 9'h0fc, 9'h0fc);
		xset(1, 1, 1, 0, 0, 0, 0, 7'h3f, 9'h0fc, 9'h0fc);
		xset(1, 0, 0, 0, 0, 0, 0, 7'h3f, 9'h0fc, 9'h0fc);
		// mid-run reset: every output returns to its reset level
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		`CHK(led, 7'h00)
		`CHK({xb_tok, xb_sout, xb_rx, xb_svc, xb_io, xb_ovf}, 6'h18)
		@(posedge mclk);
		srst <= 1'b0;
		// every initialisation failure cause, one above each limit, then cleared again
		for (int k = 0; k < 6; k++) begin
			xset(1, 1, 1, 0, k == 0, k == 1, k == 2, (k == 3) ? 7'h40 : 7'h3f, (k == 4) ? 9'h0fd : 9'h0fc,
				(k == 5) ? 9'h0fd : 9'h0fc);
			xset(1, 1, 1, 0, 0, 0, 0, 7'h3f, 9'h0fc, 9'h0fc);
		end
		end_of_test();
	end
endmodule // testbench

//--- inc/sled_pkg.sv
package sled_pkg;

	// system clock
	localparam int SLED_CLK_MHZ = 100;
	// base pattern step, in milliseconds
	localparam int SLED_STEP_MS = 50;
	// base step in clock cycles, derived from the rate
	localparam int SLED_STEP_CYC = SLED_STEP_MS * 1000 * SLED_CLK_MHZ;

	// pattern frame: 32 steps of the base step
	localparam int SLED_FRAME_W = 5;
	// on-time of one pulse, in steps
	localparam int SLED_PULSE_STEPS = 4;
	// start of the second pulse of a double flash, in steps
	localparam int SLED_SECOND_STEP = 8;

	// slave state machine codes as reported by the controller
	localparam logic [3:0] SLED_ST_INIT = 4'h1;
	localparam logic [3:0] SLED_ST_PREOP = 4'h2;
	localparam logic [3:0] SLED_ST_BOOT = 4'h3;
	localparam logic [3:0] SLED_ST_SAFEOP = 4'h4;
	localparam logic [3:0] SLED_ST_OP = 4'h8;

	// uninitialised parameter store holds this serial number
	localparam logic [31:0] SLED_SERIAL_BLANK = 32'h00000000;

	// expansion bus limits
	localparam logic [6:0] SLED_MAX_SLOTS = 7'h3f;
	localparam logic [8:0] SLED_MAX_BYTES = 9'h0fc;

	// reset values of the LED drives
	localparam logic SLED_LED_RST = 1'b0;

	// expansion status indicator states, gray along the usual path
	typedef enum logic [2:0] {
		SLED_XS_OFF = 3'b000,
		SLED_XS_CFG = 3'b001,
		SLED_XS_EXCH = 3'b011,
		SLED_XS_FAULT = 3'b010,
		SLED_XS_INITFAIL = 3'b110
	} sled_xstate_t;

	// message class on the expansion bus
	typedef enum logic {
		SLED_MSG_SERVICE = 1'b0,
		SLED_MSG_IO = 1'b1
	} sled_msg_t;

endpackage

//--- rtl/sled_pattern.sv
`timescale 1ns/100ps
// shared source of all blink patterns so every LED stays in phase
module sled_pattern #(
	parameter int STEP_CYCLES = sled_pkg::SLED_STEP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pattern levels
	output logic pat_blink,
	output logic pat_single,
	output logic pat_double,
	output logic pat_flash
);
	import sled_pkg::*;

	logic [31:0] div_reg;
	logic step_en;
	logic [SLED_FRAME_W-1:0] step_reg;

	// divider gives one enable pulse per base step
	always_ff @(posedge clk) begin
		if (rst || step_en) begin
			div_reg <= 32'h00000000;
		end else begin
			div_reg <= div_reg + 32'h00000001;
		end
	end
	assign step_en = (div_reg == 32'(STEP_CYCLES - 1));

	// frame position advances once per step
	always_ff @(posedge clk) begin
		if (rst) begin
			step_reg <= '0;
		end else if (step_en) begin
			step_reg <= step_reg + 1'b1;
		end
	end

	// decode patterns; registered so the LEDs see clean levels
	always_ff @(posedge clk) begin
		if (rst) begin
			pat_blink <= 1'b0;
			pat_single <= 1'b0;
			pat_double <= 1'b0;
			pat_flash <= 1'b0;
		end else begin
			pat_blink <= ~step_reg[2];
			pat_single <= (step_reg < SLED_FRAME_W'(SLED_PULSE_STEPS));
			pat_double <= (step_reg < SLED_FRAME_W'(SLED_PULSE_STEPS)) ||
				((step_reg >= SLED_FRAME_W'(SLED_SECOND_STEP)) &&
				(step_reg < SLED_FRAME_W'(SLED_SECOND_STEP + SLED_PULSE_STEPS)));
			pat_flash <= ~step_reg[0];
		end
	end

	// the step enable is a single-cycle pulse
	a_step_pulse: assert property (@(posedge clk) disable iff (rst)
		step_en |=> !step_en) else $error("step enable longer than one cycle");
	// blinking and single flash are both off just after step 5 of the frame
	a_blink_phase: assert property (@(posedge clk) disable iff (rst)
		(step_reg == SLED_FRAME_W'(5)) |=> (!pat_single && !pat_blink)) else $error("pattern phases wrong");

endmodule // sled_pattern

//--- rtl/sled_top.sv
`timescale 1ns/100ps
// Overview of operation
// - health LED steady green when running with no self-test fault
// - health LED flashes green while stored serial number is zero
// - health LED flashes red on parameter store checksum fault
// - health LED steady red on unrecoverable firmware fault
// - run LED: off INIT, blink PREOP, single SAFEOP, flash BOOT, on OP
// - error LED off, blink, single, double, flash or steady per error cause
// - expansion LED off without modules or without module power
// - expansion LED flashes green when configured, steady green when exchanging
// - expansion LED steady red when a module faults during exchange
// - expansion LED flashes red when expansion initialisation fails
// - field power LED green while field supply detected, else off
// - drive token and serial transmit pins, receive on serial input pin
// - tell service messages from I/O messages on the expansion bus
// - over 63 slots or 252 bytes either way is a configuration failure
module sled_top #(
	parameter int STEP_CYCLES = sled_pkg::SLED_STEP_CYC
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic SRST,
	// self-test results
	input wire logic FW_FAULT,
	input wire logic STORE_CSUM_FAULT,
	input wire logic [31:0] SERIAL_NUM,
	// slave state machine
	input wire logic [3:0] SLV_STATE,
	// error causes
	input wire logic ERR_CFG_INVALID,
	input wire logic ERR_LOCAL_CHANGE,
	input wire logic ERR_PD_WDOG,
	input wire logic ERR_BOOT,
	input wire logic ERR_PDI_WDOG,
	// expansion bus health
	input wire logic XB_UNIT_PRESENT,
	input wire logic XB_POWERED,
	input wire logic XB_CFG_PASSED,
	input wire logic XB_UNIT_FAULT,
	input wire logic XB_ID_INVALID,
	input wire logic XB_PROTO_FAIL,
	input wire logic XB_VENDOR_MISMATCH,
	input wire logic [6:0] XB_SLOT_COUNT,
	input wire logic [8:0] XB_IN_BYTES,
	input wire logic [8:0] XB_OUT_BYTES,
	// expansion bus controller side
	input wire logic XB_TOKEN_REQ,
	input wire logic XB_TX_DATA,
	input wire logic XB_FRAME_START,
	input wire sled_pkg::sled_msg_t XB_FRAME_CLASS,
	output logic XB_RX_DATA,
	output logic XB_SVC_MSG,
	output logic XB_IO_MSG,
	output logic XB_CFG_OVERFLOW,
	// expansion bus pins
	output logic XB_TOKEN_OUT,
	output logic XB_SER_OUT,
	input wire logic XB_SER_IN,
	// field power sense pin
	input wire logic FIELD_PWR_IN,
	// front panel LEDs
	output logic HEALTH_LED_GRN,
	output logic HEALTH_LED_RED,
	output logic RUN_LED,
	output logic ERR_LED,
	output logic XIO_LED_GRN,
	output logic XIO_LED_RED,
	output logic FPWR_LED
);
	import sled_pkg::*;

	logic pat_blink, pat_single, pat_double, pat_flash;
	logic fp_s1_reg, fp_s2_reg, fp_s3_reg, fp_on_reg;
	logic exch_reg;
	logic overflow;
	logic init_fail;
	sled_xstate_t xs_reg, xs_next;

	// true when a count runs past its allowed maximum
	function automatic logic over_bytes(input logic [8:0] n);
		return n > SLED_MAX_BYTES;
	endfunction

	// one pattern source for every indicator
	sled_pattern #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_pattern (
		.clk(MCLK),
		.rst(SRST),
		.pat_blink(pat_blink),
		.pat_single(pat_single),
		.pat_double(pat_double),
		.pat_flash(pat_flash)
	);

	// expansion bus pins and message classes
	sled_xbus_port u_xbus (
		.clk(MCLK),
		.rst(SRST),
		.token_req(XB_TOKEN_REQ),
		.tx_data(XB_TX_DATA),
		.frame_start(XB_FRAME_START),
		.frame_class(XB_FRAME_CLASS),
		.rx_data(XB_RX_DATA),
		.svc_msg(XB_SVC_MSG),
		.io_msg(XB_IO_MSG),
		.token_out(XB_TOKEN_OUT),
		.ser_out(XB_SER_OUT),
		.ser_in(XB_SER_IN)
	);

	// health indicator: firmware fault outranks checksum, checksum outranks blank store
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			HEALTH_LED_GRN <= SLED_LED_RST;
			HEALTH_LED_RED <= SLED_LED_RST;
		end else if (FW_FAULT) begin
			HEALTH_LED_GRN <= 1'b0;
			HEALTH_LED_RED <= 1'b1;
		end else if (STORE_CSUM_FAULT) begin
			HEALTH_LED_GRN <= 1'b0;
			HEALTH_LED_RED <= pat_flash;
		end else if (SERIAL_NUM == SLED_SERIAL_BLANK) begin
			HEALTH_LED_GRN <= pat_flash;
			HEALTH_LED_RED <= 1'b0;
		end else begin
			HEALTH_LED_GRN <= 1'b1;
			HEALTH_LED_RED <= 1'b0;
		end
	end

	// run indicator follows the slave state; unknown codes show dark
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			RUN_LED <= SLED_LED_RST;
		end else begin
			case (SLV_STATE)
				SLED_ST_INIT: RUN_LED <= 1'b0;
				SLED_ST_PREOP: RUN_LED <= pat_blink;
				SLED_ST_SAFEOP: RUN_LED <= pat_single;
				SLED_ST_BOOT: RUN_LED <= pat_flash;
				SLED_ST_OP: RUN_LED <= 1'b1;
				default: RUN_LED <= 1'b0;
			endcase
		end
	end

	// error indicator: most severe cause wins, steady beats any flashing
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			ERR_LED <= SLED_LED_RST;
		end else if (ERR_PDI_WDOG) begin
			ERR_LED <= 1'b1;
		end else if (ERR_BOOT) begin
			ERR_LED <= pat_flash;
		end else if (ERR_PD_WDOG) begin
			ERR_LED <= pat_double;
		end else if (ERR_LOCAL_CHANGE) begin
			ERR_LED <= pat_single;
		end else if (ERR_CFG_INVALID) begin
			ERR_LED <= pat_blink;
		end else begin
			ERR_LED <= 1'b0;
		end
	end

	// size limits of the expansion configuration
	assign overflow = (XB_SLOT_COUNT > SLED_MAX_SLOTS) ||
		over_bytes(XB_IN_BYTES) || over_bytes(XB_OUT_BYTES);
	assign init_fail = overflow || XB_ID_INVALID || XB_PROTO_FAIL || XB_VENDOR_MISMATCH;

	// overflow flag is also reported back to the controller
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			XB_CFG_OVERFLOW <= 1'b0;
		end else begin
			XB_CFG_OVERFLOW <= overflow;
		end
	end

	// process data exchange counts as running once an I/O message goes out
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			exch_reg <= 1'b0;
		end else if (!XB_UNIT_PRESENT || !XB_POWERED || !XB_CFG_PASSED) begin
			exch_reg <= 1'b0;
		end else if (XB_IO_MSG) begin
			exch_reg <= 1'b1;
		end
	end

	// expansion status state machine; a fault during exchange is held until power or modules go
	always_comb begin
		xs_next = xs_reg;
		case (xs_reg)
			SLED_XS_OFF: begin
				if (XB_UNIT_PRESENT && XB_POWERED) begin
					if (init_fail) begin
						xs_next = SLED_XS_INITFAIL;
					end else if (XB_CFG_PASSED) begin
						xs_next = SLED_XS_CFG;
					end
				end
			end
			SLED_XS_CFG: begin
				if (init_fail) begin
					xs_next = SLED_XS_INITFAIL;
				end else if (!XB_CFG_PASSED) begin
					xs_next = SLED_XS_OFF;
				end else if (exch_reg) begin
					xs_next = SLED_XS_EXCH;
				end
			end
			SLED_XS_EXCH: begin
				if (XB_UNIT_FAULT) begin
					xs_next = SLED_XS_FAULT;
				end else if (!exch_reg) begin
					xs_next = SLED_XS_CFG;
				end
			end
			SLED_XS_FAULT: xs_next = SLED_XS_FAULT;
			SLED_XS_INITFAIL: begin
				if (!init_fail) begin
					xs_next = SLED_XS_OFF;
				end
			end
			default: xs_next = SLED_XS_OFF;
		endcase
		// losing modules or their power always returns to dark
		if (!XB_UNIT_PRESENT || !XB_POWERED) begin
			xs_next = SLED_XS_OFF;
		end
	end

	// state register
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			xs_reg <= SLED_XS_OFF;
		end else begin
			xs_reg <= xs_next;
		end
	end

	// expansion LED drive from state
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			XIO_LED_GRN <= SLED_LED_RST;
			XIO_LED_RED <= SLED_LED_RST;
		end else begin
			case (xs_next)
				SLED_XS_CFG: begin
					XIO_LED_GRN <= pat_flash;
					XIO_LED_RED <= 1'b0;
				end
				SLED_XS_EXCH: begin
					XIO_LED_GRN <= 1'b1;
					XIO_LED_RED <= 1'b0;
				end
				SLED_XS_FAULT: begin
					XIO_LED_GRN <= 1'b0;
					XIO_LED_RED <= 1'b1;
				end
				SLED_XS_INITFAIL: begin
					XIO_LED_GRN <= 1'b0;
					XIO_LED_RED <= pat_flash;
				end
				default: begin
					XIO_LED_GRN <= 1'b0;
					XIO_LED_RED <= 1'b0;
				end
			endcase
		end
	end

	// field power sense is a raw pin: three stages, change taken on agreement
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			fp_s1_reg <= 1'b0;
			fp_s2_reg <= 1'b0;
			fp_s3_reg <= 1'b0;
			fp_on_reg <= 1'b0;
		end else begin
			fp_s1_reg <= FIELD_PWR_IN;
			fp_s2_reg <= fp_s1_reg;
			fp_s3_reg <= fp_s2_reg;
			if (fp_s2_reg == fp_s3_reg) begin
				fp_on_reg <= fp_s3_reg;
			end
		end
	end

	// field power LED; the detector itself trips well below 24 V, so this shows presence only
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			FPWR_LED <= SLED_LED_RST;
		end else begin
			FPWR_LED <= fp_on_reg;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SRST);

	a_health_green: assert property ((!FW_FAULT && !STORE_CSUM_FAULT && SERIAL_NUM != SLED_SERIAL_BLANK)
		|=> (HEALTH_LED_GRN && !HEALTH_LED_RED)) else $error("health LED not steady green");
	a_health_blank: assert property ((!FW_FAULT && !STORE_CSUM_FAULT && SERIAL_NUM == SLED_SERIAL_BLANK)
		|=> (!HEALTH_LED_RED && HEALTH_LED_GRN == $past(pat_flash))) else $error("blank store not flashing green");
	a_health_csum: assert property ((!FW_FAULT && STORE_CSUM_FAULT)
		|=> (!HEALTH_LED_GRN && HEALTH_LED_RED == $past(pat_flash))) else $error("checksum fault not flashing red");
	a_health_fw: assert property (FW_FAULT |=> (HEALTH_LED_RED && !HEALTH_LED_GRN))
		else $error("firmware fault not steady red");
	a_run_states: assert property ((SLV_STATE == SLED_ST_SAFEOP) |=> (RUN_LED == $past(pat_single)))
		else $error("run LED wrong in safe-operational");
	a_run_op: assert property ((SLV_STATE == SLED_ST_OP) ##1 (SLV_STATE == SLED_ST_OP) |=> RUN_LED[*1])
		else $error("run LED not on in operational");
	a_err_pdi: assert property (ERR_PDI_WDOG |=> ERR_LED) else $error("PDI watchdog not steady");
	a_err_double: assert property ((ERR_PD_WDOG && !ERR_PDI_WDOG && !ERR_BOOT)
		|=> (ERR_LED == $past(pat_double))) else $error("watchdog timeout not double flash");
	a_err_none: assert property (!(ERR_CFG_INVALID || ERR_LOCAL_CHANGE || ERR_PD_WDOG || ERR_BOOT || ERR_PDI_WDOG)
		|=> !ERR_LED) else $error("error LED lit with no error");
	a_xio_dark: assert property ((!XB_UNIT_PRESENT || !XB_POWERED) |=> (!XIO_LED_GRN && !XIO_LED_RED))
		else $error("expansion LED lit without modules");
	a_xio_fault: assert property ((xs_reg == SLED_XS_EXCH && XB_UNIT_FAULT && XB_UNIT_PRESENT && XB_POWERED)
		|=> (XIO_LED_RED && !XIO_LED_GRN && xs_reg == SLED_XS_FAULT)) else $error("fault in exchange not red");
	a_xio_overflow: assert property ((overflow && XB_UNIT_PRESENT && XB_POWERED && xs_reg != SLED_XS_FAULT
		&& xs_reg != SLED_XS_EXCH) |=> (!XIO_LED_GRN && xs_reg == SLED_XS_INITFAIL))
		else $error("oversize configuration accepted");
	a_fpwr_follow: assert property (FIELD_PWR_IN[*6] |=> FPWR_LED) else $error("field power LED missed supply");
	a_fpwr_drop: assert property ((!FIELD_PWR_IN)[*6] |=> !FPWR_LED) else $error("field power LED stuck on");

	c_run_op: cover property ((SLV_STATE == SLED_ST_OP) ##1 RUN_LED);
	c_err_double: cover property (ERR_PD_WDOG && !ERR_PDI_WDOG ##1 ERR_LED);
	c_xio_exch: cover property (xs_reg == SLED_XS_CFG ##1 xs_reg == SLED_XS_EXCH);
	c_xio_fault: cover property (xs_reg == SLED_XS_FAULT && XIO_LED_RED);

endmodule // sled_top

//--- rtl/sled_xbus_port.sv
`timescale 1ns/100ps
// expansion bus pins and message class tracking
module sled_xbus_port (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// controller side
	input wire logic token_req,
	input wire logic tx_data,
	input wire logic frame_start,
	input wire sled_pkg::sled_msg_t frame_class,
	output logic rx_data,
	output logic svc_msg,
	output logic io_msg,
	// bus pins
	output logic token_out,
	output logic ser_out,
	input wire logic ser_in
);
	import sled_pkg::*;

	logic rx_s1_reg, rx_s2_reg, rx_s3_reg;

	// outbound pins are driven from flops to keep them glitch free
	always_ff @(posedge clk) begin
		if (rst) begin
			token_out <= 1'b0;
			ser_out <= 1'b1;
		end else begin
			token_out <= token_req;
			ser_out <= tx_data;
		end
	end

	// receive pin is asynchronous: three stages, accept on agreement
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_s3_reg <= 1'b1;
			rx_data <= 1'b1;
		end else begin
			rx_s1_reg <= ser_in;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
			if (rx_s2_reg == rx_s3_reg) begin
				rx_data <= rx_s3_reg;
			end
		end
	end

	// classify each frame as service or process data
	always_ff @(posedge clk) begin
		if (rst) begin
			svc_msg <= 1'b0;
			io_msg <= 1'b0;
		end else begin
			svc_msg <= frame_start && (frame_class == SLED_MSG_SERVICE);
			io_msg <= frame_start && (frame_class == SLED_MSG_IO);
		end
	end

	a_token_follow: assert property (@(posedge clk) disable iff (rst)
		token_req |=> token_out) else $error("token output did not follow request");
	a_class_excl: assert property (@(posedge clk) disable iff (rst)
		frame_start |=> (svc_msg != io_msg)) else $error("frame not classified exactly once");

endmodule // sled_xbus_port
